// [hw/pwmfb_pkg.sv]
/*
  Package for the timer flag and status bank: register offsets, bit positions,
  reset values and the packed event carrier.
  Assumes a 32-bit register port with byte addresses and a single clock.
*/
package pwmfb_pkg;

  // Register byte offsets.
  localparam logic [7:0] INT_ENABLE_OFFSET = 8'h24;
  localparam logic [7:0] INT_FLAGS_OFFSET  = 8'h2c;
  localparam logic [7:0] STATUS_OFFSET     = 8'h30;

  // Interrupt flag bit positions.
  localparam int FLAG_HIT_LSB   = 16;
  localparam int FLAG_HARD1     = 15;
  localparam int FLAG_HARD0     = 14;
  localparam int FLAG_SOFT_B    = 13;
  localparam int FLAG_SOFT_A    = 12;
  localparam int FLAG_DEBUG     = 11;
  localparam int FLAG_UPDATE    = 10;
  localparam int FLAG_ERROR     = 3;
  localparam int FLAG_COUNTER   = 2;
  localparam int FLAG_RETRIGGER = 1;
  localparam int FLAG_OVERFLOW  = 0;

  // Status bit positions.
  localparam int STAT_CMP_LSB   = 24;
  localparam int STAT_BV_LSB    = 16;
  localparam int STAT_HARD_LSB  = 14;
  localparam int STAT_SOFT_B    = 13;
  localparam int STAT_SOFT_A    = 12;
  localparam int STAT_IN_LSB    = 8;
  localparam int STAT_PER_BV    = 7;
  localparam int STAT_WAVE_BV   = 6;
  localparam int STAT_PATT_BV   = 5;
  localparam int STAT_DEBUG     = 3;
  localparam int STAT_UPDATE    = 2;
  localparam int STAT_RAMP      = 1;
  localparam int STAT_STOP      = 0;

  // Reset values.
  localparam logic [31:0] INT_FLAGS_RESET  = 32'h0000_0000;
  localparam logic [31:0] INT_ENABLE_RESET = 32'h0000_0000;
  localparam logic        STOP_RESET       = 1'h1;

  // Writable masks of the flag and enable registers.
  localparam logic [31:0] FLAG_MASK = 32'h000f_fc0f;

  // Event strobes from the counter core and fault logic, one cycle each.
  typedef struct packed {
    logic [3:0] compare_match;
    logic [3:0] capture_store;
    logic [3:0] buffer_write;
    logic [3:0] cc_read;
    logic       hard_fault_one;
    logic       hard_fault_zero;
    logic       soft_fault_a;
    logic       soft_fault_b;
    logic       soft_resume_a;
    logic       soft_resume_b;
    logic       counter_event;
    logic       retrigger;
    logic       overflow;
    logic       update_cond;
    logic       stop_cmd;
    logic       count_step;
    logic       period_write;
    logic       waveform_write;
    logic       pattern_write;
  } pwmfb_event_type;

endpackage : pwmfb_pkg

// [hw/pwmfb_flag_bank.sv]
/*
  Interrupt flag and status register bank of a control timer with PWM outputs.
  Assumes event strobes synchronous to clock, count_tick marking each counter
  clock cycle, and a simple register port with read data one cycle later.
*/
// Implementation choice: the plain strobed port.
`timescale 1ns/1ns
`default_nettype none

module pwmfb_flag_bank #(
  parameter int  CHANNELS          = 4,
  parameter int  OUTPUTS           = 8,
  parameter bit  HAS_UPDATE_FAULT  = 1'b1
) (
  // Clock, reset and clock enable.
  input  wire logic                     clock,
  input  wire logic                     rst,
  input  wire logic                     clk_en,
  input  wire logic                     count_tick,
  // Register port.
  input  wire logic [7:0]               reg_addr,
  input  wire logic [31:0]              reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output logic      [31:0]              reg_rdata,
  // Event strobes.
  input  wire pwmfb_pkg::pwmfb_event_type events,
  // Levels from the counter core and fault logic.
  input  wire logic [CHANNELS-1:0]      channel_is_capture,
  input  wire logic [CHANNELS-1:0]      compare_output_level,
  input  wire logic                     hard_fault_one_input,
  input  wire logic                     hard_fault_zero_input,
  input  wire logic                     soft_fault_a_input,
  input  wire logic                     soft_fault_b_input,
  input  wire logic                     soft_halt_sw_a,
  input  wire logic                     soft_halt_sw_b,
  input  wire logic                     lock_update,
  input  wire logic                     one_shot,
  input  wire logic                     debug_mode,
  input  wire logic                     debug_fault_enable,
  input  wire logic                     two_cycle_ramp_mode,
  input  wire logic                     ramp_cycle_b,
  input  wire logic [OUTPUTS-1:0]       fault_drive_enable,
  input  wire logic [OUTPUTS-1:0]       fault_drive_value,
  // Outputs to the core and the system.
  output logic                          irq,
  output logic                          counter_halt,
  output logic [OUTPUTS-1:0]            wave_force_enable,
  output logic [OUTPUTS-1:0]            wave_force_value
);

  // Set-wins update of a group of sticky bits.
  function automatic logic [31:0] pwmfb_sticky(input logic [31:0] cur,
                                               input logic [31:0] set,
                                               input logic [31:0] clr);
    pwmfb_sticky = (cur & ~clr) | set;
  endfunction : pwmfb_sticky

  // Storage.
  logic [31:0]         int_flags;
  logic [31:0]         int_enable;
  logic [31:0]         pending;
  logic [CHANNELS-1:0] channel_buffer_valid;
  logic [1:0]          hard_fault_state;
  logic                soft_fault_a;
  logic                soft_fault_b;
  logic                period_buffer_valid;
  logic                waveform_buffer_valid;
  logic                pattern_buffer_valid;
  logic                debug_fault_state;
  logic                update_fault_state;
  logic                stopped;
  logic                ramp_cycle_bit;
  logic                ramp_prev;
  logic [CHANNELS-1:0] cmp_level;
  logic [3:0]          fault_in_level;

  // Register decode.
  wire         hit_flags   = reg_addr == pwmfb_pkg::INT_FLAGS_OFFSET;
  wire         hit_status  = reg_addr == pwmfb_pkg::STATUS_OFFSET;
  wire         hit_enable  = reg_addr == pwmfb_pkg::INT_ENABLE_OFFSET;
  wire [31:0]  flag_w1     = (reg_wr && hit_flags) ? reg_wdata : 32'h0000_0000;
  wire [31:0]  stat_w1     = (reg_wr && hit_status) ? reg_wdata : 32'h0000_0000;

  // Capture and compare events per channel.
  wire [CHANNELS-1:0] cap_ev   = events.capture_store & channel_is_capture;
  wire [CHANNELS-1:0] hit_ev   = (events.compare_match & ~channel_is_capture) | cap_ev;
  wire [CHANNELS-1:0] hit_now  = int_flags[pwmfb_pkg::FLAG_HIT_LSB +: CHANNELS];
  wire                overrun  = |(cap_ev & hit_now);
  wire [CHANNELS-1:0] cap_read = events.cc_read & channel_is_capture;
  wire                ramp_tog = ramp_cycle_bit != ramp_prev;
  wire                upd_set  = HAS_UPDATE_FAULT && ramp_tog && lock_update;
  wire                dbg_set  = debug_mode && debug_fault_enable;

  // Events waiting for the next counter clock cycle.
  logic [31:0] pend_set;
  always_comb
  begin
    pend_set = 32'h0000_0000;
    pend_set[pwmfb_pkg::FLAG_HIT_LSB +: CHANNELS] = hit_ev;
    pend_set[pwmfb_pkg::FLAG_HARD1]     = events.hard_fault_one;
    pend_set[pwmfb_pkg::FLAG_HARD0]     = events.hard_fault_zero;
    pend_set[pwmfb_pkg::FLAG_SOFT_B]    = events.soft_fault_b;
    pend_set[pwmfb_pkg::FLAG_SOFT_A]    = events.soft_fault_a;
    pend_set[pwmfb_pkg::FLAG_DEBUG]     = dbg_set && !debug_fault_state;
    pend_set[pwmfb_pkg::FLAG_COUNTER]   = events.counter_event;
    pend_set[pwmfb_pkg::FLAG_RETRIGGER] = events.retrigger;
    pend_set[pwmfb_pkg::FLAG_OVERFLOW]  = events.overflow;
  end

  // Flags set at once, and clears by write or by capture read.
  logic [31:0] now_set;
  logic [31:0] flag_clr;
  always_comb
  begin
    now_set = 32'h0000_0000;
    now_set[pwmfb_pkg::FLAG_UPDATE] = upd_set;
    now_set[pwmfb_pkg::FLAG_ERROR]  = overrun;
    flag_clr = flag_w1 & pwmfb_pkg::FLAG_MASK;
    flag_clr[pwmfb_pkg::FLAG_HIT_LSB +: CHANNELS] =
      flag_w1[pwmfb_pkg::FLAG_HIT_LSB +: CHANNELS] | cap_read;
  end

  wire [31:0] tick_set   = count_tick ? pending : 32'h0000_0000;
  wire [31:0] next_pend  = count_tick ? pend_set : (pending | pend_set);
  wire [31:0] next_flags = pwmfb_sticky(int_flags, tick_set | now_set, flag_clr);

  // Buffer valid bits of the channels.
  logic [CHANNELS-1:0] bv_set;
  logic [CHANNELS-1:0] bv_clr;
  always_comb
  begin
    bv_set = (events.buffer_write & ~channel_is_capture) | cap_ev;
    bv_clr = ((stat_w1[pwmfb_pkg::STAT_BV_LSB +: CHANNELS] & {CHANNELS{lock_update}})
             | {CHANNELS{events.update_cond}}) & ~channel_is_capture;
    bv_clr = bv_clr | cap_read;
  end
  wire [CHANNELS-1:0] next_bv = (channel_buffer_valid & ~bv_clr) | bv_set;

  // Fault state bits.
  wire [1:0] hard_in  = {hard_fault_one_input, hard_fault_zero_input};
  wire [1:0] hard_ev  = {events.hard_fault_one, events.hard_fault_zero};
  wire [1:0] hard_clr = stat_w1[pwmfb_pkg::STAT_HARD_LSB +: 2] & ~hard_in;
  wire [1:0] next_hard = (hard_fault_state & ~hard_clr) | hard_ev;
  wire soft_a_clr = events.soft_resume_a
                    || (stat_w1[pwmfb_pkg::STAT_SOFT_A] && !soft_fault_a_input);
  wire soft_b_clr = events.soft_resume_b
                    || (stat_w1[pwmfb_pkg::STAT_SOFT_B] && !soft_fault_b_input);
  wire next_soft_a = (soft_fault_a && !soft_a_clr) || events.soft_fault_a;
  wire next_soft_b = (soft_fault_b && !soft_b_clr) || events.soft_fault_b;

  // Period, waveform and pattern buffer valid bits.
  wire upd_lock = events.update_cond && lock_update;
  wire next_per  = (period_buffer_valid
                    && !(upd_lock || stat_w1[pwmfb_pkg::STAT_PER_BV]))
                   || events.period_write;
  wire next_wave = (waveform_buffer_valid
                    && !(upd_lock || stat_w1[pwmfb_pkg::STAT_WAVE_BV]))
                   || events.waveform_write;
  wire next_patt = (pattern_buffer_valid
                    && !(upd_lock || stat_w1[pwmfb_pkg::STAT_PATT_BV]))
                   || events.pattern_write;

  // Debug, update fault and stopped state bits.
  wire next_dbg  = (debug_fault_state
                    && !(stat_w1[pwmfb_pkg::STAT_DEBUG] && !debug_mode))
                   || dbg_set;
  wire next_ufs  = (update_fault_state && !stat_w1[pwmfb_pkg::STAT_UPDATE]) || upd_set;
  wire stop_set  = events.stop_cmd || (events.update_cond && one_shot);
  wire next_stop = (stopped && !events.count_step) || stop_set;
  wire next_ramp = two_cycle_ramp_mode && ramp_cycle_b;

  // Status word as software sees it.
  logic [31:0] status_word;
  always_comb
  begin
    status_word = 32'h0000_0000;
    status_word[pwmfb_pkg::STAT_CMP_LSB +: CHANNELS] = cmp_level;
    status_word[pwmfb_pkg::STAT_BV_LSB +: CHANNELS]  = channel_buffer_valid;
    status_word[pwmfb_pkg::STAT_HARD_LSB +: 2]       = hard_fault_state;
    status_word[pwmfb_pkg::STAT_SOFT_B]              = soft_fault_b;
    status_word[pwmfb_pkg::STAT_SOFT_A]              = soft_fault_a;
    status_word[pwmfb_pkg::STAT_IN_LSB +: 4]         = fault_in_level;
    status_word[pwmfb_pkg::STAT_PER_BV]              = period_buffer_valid;
    status_word[pwmfb_pkg::STAT_WAVE_BV]             = waveform_buffer_valid;
    status_word[pwmfb_pkg::STAT_PATT_BV]             = pattern_buffer_valid;
    status_word[pwmfb_pkg::STAT_DEBUG]               = debug_fault_state;
    status_word[pwmfb_pkg::STAT_UPDATE]              = update_fault_state;
    status_word[pwmfb_pkg::STAT_RAMP]                = ramp_cycle_bit;
    status_word[pwmfb_pkg::STAT_STOP]                = stopped;
  end

  // Read data selection; unmapped addresses read zero.
  wire [31:0] read_sel = hit_flags  ? int_flags :
                         hit_status ? status_word :
                         hit_enable ? int_enable : 32'h0000_0000;
  wire [31:0] next_enable = (reg_wr && hit_enable) ? (reg_wdata & pwmfb_pkg::FLAG_MASK)
                                                   : int_enable;

  // Halt and forced drive, as seen by the counter core next cycle.
  wire next_halt = debug_fault_state || (|hard_fault_state)
                   || (soft_fault_a && soft_halt_sw_a)
                   || (soft_fault_b && soft_halt_sw_b);
  wire                next_irq    = |(int_flags & int_enable);
  wire                force_on    = debug_fault_state || (|hard_fault_state);
  wire [OUTPUTS-1:0]  next_fen    = force_on ? fault_drive_enable : '0;
  wire [OUTPUTS-1:0]  next_fval   = force_on ? fault_drive_value  : '0;

  // Flag and enable registers.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      int_flags  <= pwmfb_pkg::INT_FLAGS_RESET;
      int_enable <= pwmfb_pkg::INT_ENABLE_RESET;
      pending    <= 32'h0000_0000;
    end
    else if (clk_en)
    begin
      int_flags  <= next_flags;
      int_enable <= next_enable;
      pending    <= next_pend;
    end
  end

  // Status state bits.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      channel_buffer_valid  <= '0;
      hard_fault_state      <= 2'h0;
      soft_fault_a          <= 1'h0;
      soft_fault_b          <= 1'h0;
      period_buffer_valid   <= 1'h0;
      waveform_buffer_valid <= 1'h0;
      pattern_buffer_valid  <= 1'h0;
      debug_fault_state     <= 1'h0;
      update_fault_state    <= 1'h0;
      stopped               <= pwmfb_pkg::STOP_RESET;
      ramp_cycle_bit        <= 1'h0;
      ramp_prev             <= 1'h0;
    end
    else if (clk_en)
    begin
      channel_buffer_valid  <= next_bv;
      hard_fault_state      <= next_hard;
      soft_fault_a          <= next_soft_a;
      soft_fault_b          <= next_soft_b;
      period_buffer_valid   <= next_per;
      waveform_buffer_valid <= next_wave;
      pattern_buffer_valid  <= next_patt;
      debug_fault_state     <= next_dbg;
      update_fault_state    <= HAS_UPDATE_FAULT && next_ufs;
      stopped               <= next_stop;
      ramp_cycle_bit        <= next_ramp;
      ramp_prev             <= ramp_cycle_bit;
    end
  end

  // Sampled levels and registered outputs.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      cmp_level         <= '0;
      fault_in_level    <= 4'h0;
      reg_rdata         <= 32'h0000_0000;
      irq               <= 1'h0;
      counter_halt      <= 1'h0;
      wave_force_enable <= '0;
      wave_force_value  <= '0;
    end
    else if (clk_en)
    begin
      cmp_level         <= compare_output_level;
      fault_in_level    <= {hard_fault_one_input, hard_fault_zero_input,
                            soft_fault_b_input, soft_fault_a_input};
      reg_rdata         <= reg_rd ? read_sel : 32'h0000_0000;
      irq               <= next_irq;
      counter_halt      <= next_halt;
      wave_force_enable <= next_fen;
      wave_force_value  <= next_fval;
    end
  end

endmodule : pwmfb_flag_bank

`default_nettype wire

// [testbench/pwmfb_flag_bank_assertions.sv]
/*
  Concurrent checks on the ports of the timer flag and status bank.
  Assumes one clock, a synchronous active-high reset and the package offsets.
*/
`timescale 1ns/1ns
`default_nettype none

module pwmfb_flag_bank_assertions #(
  parameter int CHANNELS         = 4,
  parameter int OUTPUTS          = 8,
  parameter bit HAS_UPDATE_FAULT = 1'b1
) (
  // Clock, reset and timing.
  input wire logic                       clock,
  input wire logic                       rst,
  input wire logic                       clk_en,
  input wire logic                       count_tick,
  // Register port.
  input wire logic [7:0]                 reg_addr,
  input wire logic [31:0]                reg_wdata,
  input wire logic                       reg_wr,
  input wire logic                       reg_rd,
  input wire logic [31:0]                reg_rdata,
  // Strobes and levels.
  input wire pwmfb_pkg::pwmfb_event_type events,
  input wire logic [CHANNELS-1:0]        compare_output_level,
  input wire logic                       hard_fault_one_input,
  input wire logic                       hard_fault_zero_input,
  input wire logic                       soft_fault_a_input,
  input wire logic                       soft_fault_b_input,
  input wire logic                       lock_update,
  input wire logic                       debug_mode,
  input wire logic                       debug_fault_enable,
  input wire logic [OUTPUTS-1:0]         fault_drive_enable,
  input wire logic [OUTPUTS-1:0]         fault_drive_value,
  // Outputs watched.
  input wire logic                       counter_halt,
  input wire logic [OUTPUTS-1:0]         wave_force_enable,
  input wire logic [OUTPUTS-1:0]         wave_force_value
);

  default clocking @(posedge clock);
  endclocking
  default disable iff (rst);

  // Decoded accesses and a cycle with no flag source active.
  wire       rd_st = reg_rd && clk_en && reg_addr == pwmfb_pkg::STATUS_OFFSET;
  wire       rd_fl = reg_rd && clk_en && reg_addr == pwmfb_pkg::INT_FLAGS_OFFSET;
  wire       wr_fl = reg_wr && clk_en && reg_addr == pwmfb_pkg::INT_FLAGS_OFFSET;
  wire       rd_en = reg_rd && clk_en && reg_addr == pwmfb_pkg::INT_ENABLE_OFFSET;
  wire       wr_en = reg_wr && clk_en && reg_addr == pwmfb_pkg::INT_ENABLE_OFFSET;
  wire       quiet = !count_tick && events == '0 && !lock_update && !reg_wr;
  wire [3:0] fin   = {hard_fault_one_input, hard_fault_zero_input,
                      soft_fault_b_input, soft_fault_a_input};

  AST_RESET_STATUS:
    assert property ($past(rst) && rd_st |=> reg_rdata == 32'h1)
      else $error("status after reset is not the reset value");
  AST_CMP_LEVELS:
    assert property (rd_st && !$past(rst) && $past(clk_en) && $stable(compare_output_level)
      |=> reg_rdata[27:24] == $past(compare_output_level, 2))
      else $error("status compare levels differ from the inputs");
  AST_FAULT_INPUTS:
    assert property (rd_st && !$past(rst) && $past(clk_en) && $stable(fin)
      |=> reg_rdata[11:8] == $past(fin, 2))
      else $error("status fault input bits differ from the inputs");
  AST_ENABLE_READBACK:
    assert property (wr_en ##1 !reg_wr ##1 rd_en
      |=> reg_rdata == ($past(reg_wdata, 3) & pwmfb_pkg::FLAG_MASK))
      else $error("enable register does not read back");
  AST_W1C_FLAGS:
    assert property (wr_fl && !count_tick && events == '0 && !lock_update ##1 quiet ##1 rd_fl
      |=> (reg_rdata & $past(reg_wdata, 3) & pwmfb_pkg::FLAG_MASK) == 32'h0)
      else $error("flag survived a write of one");
  AST_HARD_STATE_SET:
    assert property (events.hard_fault_zero && clk_en ##1 !reg_wr ##1 rd_st |=> reg_rdata[14])
      else $error("hard fault state not set at once");
  AST_DEBUG_HALT:
    assert property ((clk_en && debug_mode && debug_fault_enable)[*2] |=> counter_halt)
      else $error("counter not halted in debug fault state");
  AST_DEBUG_DRIVE:
    assert property ((clk_en && debug_mode && debug_fault_enable)[*2]
      |=> wave_force_enable == $past(fault_drive_enable)
      && ((wave_force_value ^ $past(fault_drive_value)) & $past(fault_drive_enable)) == '0)
      else $error("outputs do not follow fault drive settings");

endmodule : pwmfb_flag_bank_assertions

bind pwmfb_flag_bank pwmfb_flag_bank_assertions #(
  .CHANNELS(CHANNELS), .OUTPUTS(OUTPUTS), .HAS_UPDATE_FAULT(HAS_UPDATE_FAULT)
) i_pwmfb_flag_bank_assertions (
  .clock, .rst, .clk_en, .count_tick, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .events, .compare_output_level, .hard_fault_one_input, .hard_fault_zero_input,
  .soft_fault_a_input, .soft_fault_b_input, .lock_update, .debug_mode,
  .debug_fault_enable, .fault_drive_enable, .fault_drive_value, .counter_halt,
  .wave_force_enable, .wave_force_value
);

`default_nettype wire

// [testbench/pwmfb_flag_bank_bench.sv]
/*
  Self-checking bench of the timer flag and status bank.
  Assumes the package constants; the bench drives every port itself.
*/
`timescale 1ns/1ns
`default_nettype none

module pwmfb_flag_bank_bench;

  // Design ports and bench state.
  logic clock, rst, clk_en, count_tick, reg_wr, reg_rd, irq, counter_halt;
  logic hard_fault_one_input, hard_fault_zero_input, soft_fault_a_input, soft_fault_b_input;
  logic lock_update, debug_mode, debug_fault_enable, two_cycle_ramp_mode, ramp_cycle_b;
  logic soft_halt_sw, one_shot;
  logic [7:0] reg_addr, fault_drive_enable, fault_drive_value;
  logic [7:0] wave_force_enable, wave_force_value;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic [3:0] channel_is_capture, compare_output_level;
  pwmfb_pkg::pwmfb_event_type events;
  int n_mismatch, n_tests;
  localparam logic [7:0] FL = pwmfb_pkg::INT_FLAGS_OFFSET;
  localparam logic [7:0] ST = pwmfb_pkg::STATUS_OFFSET;
  // Rows: strobe bit inside the event struct, and the flag bit it raises.
  int ev_bit [11] = '{6, 7, 8, 11, 12, 13, 14, 27, 28, 29, 30};
  int fl_bit [11] = '{0, 1, 2, 13, 12, 14, 15, 16, 17, 18, 19};

  pwmfb_flag_bank i_pwmfb_flag_bank (
    .clock, .rst, .clk_en, .count_tick, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .events, .channel_is_capture, .compare_output_level,
    .hard_fault_one_input, .hard_fault_zero_input, .soft_fault_a_input,
    .soft_fault_b_input, .soft_halt_sw_a(soft_halt_sw), .soft_halt_sw_b(soft_halt_sw),
    .lock_update, .one_shot, .debug_mode, .debug_fault_enable, .two_cycle_ramp_mode,
    .ramp_cycle_b, .fault_drive_enable, .fault_drive_value, .irq, .counter_halt,
    .wave_force_enable, .wave_force_value
  );

  // Free-running 8 ns clock.
  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // Compares one value and counts it.
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_tests++;
    if (seen !== want)
    begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, want);
    end
  endtask : check

  // Compares the masked last read word.
  task automatic chk(input logic [31:0] m, input logic [31:0] w);
    check(d & m, w);
  endtask : chk

  // One register write cycle.
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr

  // One register read; the data is taken in the cycle after the strobe.
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    d = reg_rdata;
  endtask : rd

  // One-cycle strobe on the event struct.
  task automatic pulse(input logic [30:0] v);
    @(posedge clock);
    events <= pwmfb_pkg::pwmfb_event_type'(v);
    @(posedge clock);
    events <= '0;
  endtask : pulse

  // One counter clock cycle.
  task automatic tick;
    @(posedge clock);
    count_tick <= 1'b1;
    @(posedge clock);
    count_tick <= 1'b0;
  endtask : tick

  // Lets pending flags land, then clears all flags.
  task automatic flush(input string s);
    tick;
    wr(FL, 32'hffff_ffff);
    $display("test %s finished", s);
  endtask : flush

  // Prints the counts and the verdict, then stops.
  task automatic wrap_up;
    $display("%0d comparisons, %0d mismatches", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : wrap_up

  // Cuts a hang short.
  initial
  begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    wrap_up;
  end

  // Main sequence.
  initial
  begin
    {rst, clk_en} = 2'b11;
    {count_tick, reg_wr, reg_rd, lock_update, debug_mode, debug_fault_enable} = '0;
    {hard_fault_one_input, hard_fault_zero_input, soft_fault_a_input} = '0;
    {soft_fault_b_input, two_cycle_ramp_mode, ramp_cycle_b} = '0;
    {soft_halt_sw, one_shot} = '0;
    {reg_addr, reg_wdata, channel_is_capture} = '0;
    events = '0;
    compare_output_level = 4'ha;
    fault_drive_enable = 8'h5a;
    fault_drive_value = 8'h33;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    reg_rd <= 1'b1;
    reg_addr <= ST;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    check(reg_rdata, 32'h1);
    rd(FL);
    check(d, 32'h0);
    rd(8'h10);
    check(d, 32'h0);
    wr(8'h24, 32'hffff_ffff);
    rd(8'h24);
    check(d, pwmfb_pkg::FLAG_MASK);
    for (int i = 0; i < 11; i++)
    begin
      pulse(31'(1) << ev_bit[i]);
      rd(FL);
      check(d, 32'h0);
      tick;
      rd(FL);
      check(d, 32'(1) << fl_bit[i]);
      check({31'h0, irq}, 32'h1);
      wr(FL, ~(32'(1) << fl_bit[i]));
      rd(FL);
      check(d, 32'(1) << fl_bit[i]);
      wr(FL, 32'(1) << fl_bit[i]);
      rd(FL);
      check(d | {31'h0, irq}, 32'h0);
      wr(ST, 32'hffff_ffff);
    end
    $display("test flag table finished");
    channel_is_capture <= 4'h1;
    pulse(31'(1) << 23);
    rd(ST);
    chk(32'h1_0000, 32'h1_0000);
    tick;
    pulse(31'(1) << 23);
    rd(FL);
    check(d, 32'h0001_0008);
    pulse(31'(1) << 15);
    rd(FL);
    check(d, 32'h8);
    rd(ST);
    chk(32'h1_0000, 32'h0);
    channel_is_capture <= 4'h0;
    flush("capture");
    pulse((31'(1) << 20) | 31'h7);
    rd(ST);
    chk(32'h00ff_00e0, 32'h0002_00e0);
    wr(ST, 32'h0002_0000);
    rd(ST);
    chk(32'h00ff_00e0, 32'h0002_00e0);
    pulse(31'h20);
    rd(ST);
    chk(32'h00ff_00e0, 32'h0000_00e0);
    lock_update <= 1'b1;
    wr(ST, 32'h80);
    pulse(31'h20);
    pulse(31'(1) << 20);
    wr(ST, 32'h0002_0000);
    rd(ST);
    chk(32'h00ff_00e0, 32'h0);
    lock_update <= 1'b0;
    flush("buffer valid");
    hard_fault_zero_input <= 1'b1;
    pulse(31'(1) << 13);
    rd(ST);
    chk(32'h4400, 32'h4400);
    wr(ST, 32'h4000);
    rd(ST);
    chk(32'h4000, 32'h4000);
    hard_fault_zero_input <= 1'b0;
    wr(ST, 32'h4000);
    rd(ST);
    chk(32'h4400, 32'h0);
    soft_halt_sw <= 1'b1;
    soft_fault_a_input <= 1'b1;
    pulse(31'(1) << 12);
    rd(ST);
    chk(32'h1100, 32'h1100);
    check({31'h0, counter_halt}, 32'h1);
    soft_fault_a_input <= 1'b0;
    pulse(31'(1) << 10);
    rd(ST);
    chk(32'h1100, 32'h0);
    check({31'h0, counter_halt}, 32'h0);
    flush("fault states");
    debug_mode <= 1'b1;
    debug_fault_enable <= 1'b1;
    rd(ST);
    chk(32'h8, 32'h8);
    check({31'h0, counter_halt}, 32'h1);
    check({16'h0, wave_force_enable, wave_force_value & wave_force_enable}, 32'h5a12);
    wr(ST, 32'h8);
    rd(ST);
    chk(32'h8, 32'h8);
    debug_mode <= 1'b0;
    wr(ST, 32'h8);
    rd(ST);
    chk(32'h8, 32'h0);
    debug_fault_enable <= 1'b0;
    pulse(31'h8);
    rd(ST);
    chk(32'h0f00_0001, 32'h0a00_0000);
    pulse(31'h10);
    rd(ST);
    chk(32'h1, 32'h1);
    pulse(31'h8);
    one_shot <= 1'b1;
    pulse(31'h20);
    rd(ST);
    chk(32'h1, 32'h1);
    one_shot <= 1'b0;
    flush("debug and stop");
    two_cycle_ramp_mode <= 1'b1;
    ramp_cycle_b <= 1'b1;
    rd(ST);
    chk(32'h2, 32'h2);
    lock_update <= 1'b1;
    ramp_cycle_b <= 1'b0;
    @(posedge clock);
    rd(FL);
    chk(32'h400, 32'h400);
    rd(ST);
    chk(32'h6, 32'h4);
    lock_update <= 1'b0;
    two_cycle_ramp_mode <= 1'b0;
    ramp_cycle_b <= 1'b1;
    rd(ST);
    chk(32'h2, 32'h0);
    flush("ramp");
    wrap_up;
  end

endmodule : pwmfb_flag_bank_bench

`default_nettype wire
